// ===== logic/alc_pkg.sv
// Constants, register map and timing for the input level controller
// Summary of operation
// R1 - Controller runs only while enable bit set
// R2 - Mode bit picks normal or limiter behaviour
// R3 - Disabled: amplifier keeps last controller gain
// R4 - Floor field: -12 dB plus 6 dB per code
// R5 - Ceiling field: -6.75 dB plus 6 dB per code
// R6 - Target field: -28.5 to -6 dB, 1.5 dB steps
// R7 - Hold delay from zero, doubling per code
// R8 - Attack step period doubles per code, mode range
// R9 - Decay step period doubles per code, mode range
// R10 - Applied gain clamped between floor and ceiling
// R11 - Enabled: software gain setting ignored
// R12 - Limiter: ceiling is gain at enable
// R13 - Lower above target, raise below target-1.5dB
// R14 - Normal mode: hold time passes before any gain increase
// R15 - Above 87.5% full scale: fastest attack
// R16 - Envelope above target starts attack stepping
// R17 - Peak loads larger samples, else decays
// R18 - Skip step if window ever crossed threshold
// R19 - Decay governs increases; limiter decays faster
// R20 - Noise gate enable and level register
// R21 - Gated quiet input: gain held constant; the code blocks only increases while gated, attack steps still lower it
// R22 - Gate only when enabled and normal mode
// R23 - Input is signed 1.23 decimator output
// R24 - Zero-cross option: change gain at crossings
// R25 - No crossing in 0.25 s: apply anyway
// R26 - One step per timer expiry, then clamp
package alc_pkg;
	localparam logic [7:0] IDX_LIMITS  = 8'h20;
	localparam logic [7:0] IDX_TARGET  = 8'h21;
	localparam logic [7:0] IDX_TIMING  = 8'h22;
	localparam logic [7:0] IDX_GATE    = 8'h23;
	localparam logic [7:0] IDX_AMP     = 8'h2d;
	localparam logic [7:0] IDX_STATUS  = 8'h30;
	localparam logic [7:0] IDX_PEAK    = 8'h31;
	localparam logic [9:0] ADR_LIMITS  = {IDX_LIMITS, 2'b00};
	localparam logic [9:0] ADR_TARGET  = {IDX_TARGET, 2'b00};
	localparam logic [9:0] ADR_TIMING  = {IDX_TIMING, 2'b00};
	localparam logic [9:0] ADR_GATE    = {IDX_GATE, 2'b00};
	localparam logic [9:0] ADR_AMP     = {IDX_AMP, 2'b00};
	localparam logic [9:0] ADR_STATUS  = {IDX_STATUS, 2'b00};
	localparam logic [9:0] ADR_PEAK    = {IDX_PEAK, 2'b00};
	localparam int         POS_ON      = 8;
	localparam int         POS_MODE    = 8;
	localparam int         POS_ZC      = 8;
	localparam int         POS_GATE_ON = 3;
	localparam logic [8:0] RST_CFG     = 9'h000;
	localparam logic [5:0] RST_AMP     = 6'h00;
	localparam logic [3:0] MAX_CODE    = 4'ha;
	localparam int unsigned CLK_MHZ    = 200;
	localparam int unsigned ATK_N_US   = 125;
	localparam int unsigned ATK_L_US   = 31;
	localparam int unsigned DCY_N_US   = 500;
	localparam int unsigned DCY_L_US   = 125;
	localparam int unsigned HOLD_MS    = 2;
	localparam int unsigned ZC_MS      = 250;
	localparam int unsigned ATK_N_CYC  = ATK_N_US * CLK_MHZ;
	localparam int unsigned ATK_L_CYC  = ATK_L_US * CLK_MHZ;
	localparam int unsigned DCY_N_CYC  = DCY_N_US * CLK_MHZ;
	localparam int unsigned DCY_L_CYC  = DCY_L_US * CLK_MHZ;
	localparam int unsigned HOLD_CYC   = HOLD_MS * 1000 * CLK_MHZ;
	localparam int unsigned ZC_CYC     = ZC_MS * 1000 * CLK_MHZ;
	localparam logic [11:0] CLIP_LVL   = 12'h700;
	// Magnitudes on a 2048 full-scale grid; entry 0 is -30 dB
	localparam logic [11:0] LVL_TAB [17] = '{12'h041, 12'h04d, 12'h05b, 12'h06d, 12'h081,
		12'h09a, 12'h0b7, 12'h0d9, 12'h102, 12'h132, 12'h16c, 12'h1b1, 12'h202,
		12'h263, 12'h2d7, 12'h360, 12'h402};
endpackage : alc_pkg

// ===== logic/input_auto_level_control.sv
// Input level controller with peak detector, limiter, noise gate, APB regs
`timescale 1ns/10ps
module input_auto_level_control #(
	parameter int unsigned ATK_N_BASE = alc_pkg::ATK_N_CYC,
	parameter int unsigned ATK_L_BASE = alc_pkg::ATK_L_CYC,
	parameter int unsigned DCY_N_BASE = alc_pkg::DCY_N_CYC,
	parameter int unsigned DCY_L_BASE = alc_pkg::DCY_L_CYC,
	parameter int unsigned HOLD_BASE  = alc_pkg::HOLD_CYC,
	parameter int unsigned ZC_TIMEOUT = alc_pkg::ZC_CYC,
	parameter int unsigned PEAK_SHIFT = 12
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [23:0] adc_sample,
	input  wire logic        adc_valid,
	output logic      [5:0]  amp_gain
);
	logic [8:0]  limits_q;
	logic [8:0]  target_q;
	logic [8:0]  timing_q;
	logic [8:0]  gate_q;
	logic [5:0]  amp_set_q;
	logic [5:0]  amp_q;
	logic [5:0]  ctrl_q;
	logic [5:0]  ctrl_d;
	logic [5:0]  cap_q;
	logic        on_q;
	logic [23:0] peak_q;
	logic [23:0] abs_s;
	logic [23:0] dec_amt;
	logic [31:0] atk_cnt_q;
	logic [31:0] dcy_cnt_q;
	logic [31:0] hold_cnt_q;
	logic [31:0] zc_cnt_q;
	logic [31:0] atk_per;
	logic [31:0] dcy_per;
	logic [31:0] hold_per;
	logic        dn_ok_q;
	logic        up_ok_q;
	logic        clip_q;
	logic        sign_q;
	logic        rd_err;
	logic [31:0] rd_mux;
	logic [31:0] prdata_q;
	logic        pslverr_q;

	logic        on;
	logic        lim;
	logic        zc_en;
	logic        wr;
	logic        amp_wr;
	logic [11:0] pk12;
	logic [11:0] thr_hi;
	logic [11:0] thr_lo;
	logic        above;
	logic        low;
	logic        gated;
	logic        atk_tick;
	logic        dcy_tick;
	logic        hold_done;
	logic        dn_step;
	logic        up_step;
	logic [5:0]  lo;
	logic [5:0]  hi;
	logic        pending;
	logic        zc_evt;
	logic        apply;

	function automatic logic [31:0] period(input int unsigned base, input logic [3:0] code);
		logic [3:0] c;
		c = (code > alc_pkg::MAX_CODE) ? alc_pkg::MAX_CODE : code;
		period = 32'(base) << c;
	endfunction : period

	function automatic logic [5:0] clamp(input logic [5:0] v, input logic [5:0] l,
		input logic [5:0] h);
		logic [5:0] r;
		r = (v > h) ? h : v;
		clamp = (r < l) ? l : r;
	endfunction : clamp

	// R1 enable, R2 mode select
	assign on    = limits_q[alc_pkg::POS_ON];
	assign lim   = timing_q[alc_pkg::POS_MODE];
	assign zc_en = target_q[alc_pkg::POS_ZC];
	assign wr    = psel & penable & pwrite;
	assign amp_wr = wr && (paddr == alc_pkg::ADR_AMP);

	// APB: no wait states, data and error latched in setup
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	always_comb
	begin
		rd_err = 1'b0;
		rd_mux = 32'h0000_0000;
		if (paddr == alc_pkg::ADR_LIMITS)
			rd_mux = {23'h0, limits_q};
		else if (paddr == alc_pkg::ADR_TARGET)
			rd_mux = {23'h0, target_q};
		else if (paddr == alc_pkg::ADR_TIMING)
			rd_mux = {23'h0, timing_q};
		else if (paddr == alc_pkg::ADR_GATE)
			rd_mux = {23'h0, gate_q};
		else if (paddr == alc_pkg::ADR_AMP)
			rd_mux = {26'h0, amp_set_q};
		else if (paddr == alc_pkg::ADR_STATUS)
			rd_mux = {22'h0, gated, clip_q, 2'b00, amp_q};
		else if (paddr == alc_pkg::ADR_PEAK)
			rd_mux = {8'h00, peak_q};
		else
			rd_err = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= rd_err;
		end
	end

	// R20 gate config among the stored fields
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			limits_q  <= alc_pkg::RST_CFG;
			target_q  <= alc_pkg::RST_CFG;
			timing_q  <= alc_pkg::RST_CFG;
			gate_q    <= alc_pkg::RST_CFG;
			amp_set_q <= alc_pkg::RST_AMP;
		end
		else if (wr)
		begin
			if (paddr == alc_pkg::ADR_LIMITS)
				limits_q <= pwdata[8:0];
			else if (paddr == alc_pkg::ADR_TARGET)
				target_q <= pwdata[8:0];
			else if (paddr == alc_pkg::ADR_TIMING)
				timing_q <= pwdata[8:0];
			else if (paddr == alc_pkg::ADR_GATE)
				gate_q <= {5'h00, pwdata[3:0]};
			else if (paddr == alc_pkg::ADR_AMP)
				amp_set_q <= pwdata[5:0];
		end
	end

	// R23 signed 1.23 sample; full negative scale folds to 2^23
	assign abs_s   = adc_sample[23] ? 24'(-adc_sample) : adc_sample;
	assign dec_amt = ((peak_q >> PEAK_SHIFT) == 24'h0) ? 24'h1 : (peak_q >> PEAK_SHIFT);

	// R17 load on larger sample, otherwise decay
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			peak_q <= 24'h0;
		else if (adc_valid)
			peak_q <= (abs_s > peak_q) ? abs_s :
				((peak_q > dec_amt) ? peak_q - dec_amt : 24'h0);
	end

	// R6 target table, R13 lower threshold one step below
	assign pk12   = peak_q[23:12];
	assign thr_hi = alc_pkg::LVL_TAB[5'(target_q[3:0]) + 5'd1];
	assign thr_lo = alc_pkg::LVL_TAB[target_q[3:0]];
	assign above  = pk12 > thr_hi;
	assign low    = pk12 < thr_lo;
	// R21 R22 gate level ladder of 6 dB steps
	assign gated  = on && !lim && gate_q[alc_pkg::POS_GATE_ON] &&
		(peak_q < (24'h01_0000 << gate_q[2:0]));

	// R8 R15 attack base by mode; clip forces code zero
	assign atk_per = period(lim ? ATK_L_BASE : ATK_N_BASE, clip_q ? 4'h0 : timing_q[3:0]);
	// R9 R19 limiter uses the shorter decay base
	assign dcy_per = period(lim ? DCY_L_BASE : DCY_N_BASE, timing_q[7:4]);
	// R7 hold zero at code 0, else doubling
	assign hold_per = (target_q[7:4] == 4'h0) ? 32'h0 :
		(period(HOLD_BASE, target_q[7:4]) >> 1);

	assign atk_tick  = on && (atk_cnt_q >= atk_per - 32'h1);
	assign dcy_tick  = on && (dcy_cnt_q >= dcy_per - 32'h1);
	// R14 hold applies in normal mode only
	assign hold_done = lim || (hold_cnt_q >= hold_per);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			atk_cnt_q <= 32'h0;
			dcy_cnt_q <= 32'h0;
		end
		else
		begin
			atk_cnt_q <= (!on || atk_tick) ? 32'h0 : atk_cnt_q + 32'h1;
			dcy_cnt_q <= (!on || dcy_tick) ? 32'h0 : dcy_cnt_q + 32'h1;
		end
	end

	// R14 count while envelope sits below range
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hold_cnt_q <= 32'h0;
		else if (!on || !low)
			hold_cnt_q <= 32'h0;
		else if (hold_cnt_q < hold_per)
			hold_cnt_q <= hold_cnt_q + 32'h1;
	end

	// R18 window flags restart at each tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dn_ok_q <= 1'b0;
			up_ok_q <= 1'b0;
		end
		else
		begin
			dn_ok_q <= (atk_tick || !on) ? above : (dn_ok_q && above);
			up_ok_q <= (dcy_tick || !on) ? low : (up_ok_q && low);
		end
	end

	// R15 clip until envelope back under target
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clip_q <= 1'b0;
		else if (on && adc_valid && abs_s[23:12] > alc_pkg::CLIP_LVL)
			clip_q <= 1'b1;
		else if (!on || !above)
			clip_q <= 1'b0;
	end

	// R16 R18 decrease only if above for the whole window
	assign dn_step = atk_tick && dn_ok_q && above;
	// R13 R18 R21 raise only after hold and outside the gate
	assign up_step = dcy_tick && up_ok_q && low && hold_done && !gated && !clip_q;

	// R4 R5 R12 limits in 0.75 dB gain codes
	assign lo = {limits_q[2:0], 3'b000};
	// Enabling cycle uses live gain; cap_q lands one edge late
	assign hi = lim ? (on_q ? cap_q : amp_q) : {limits_q[5:3], 3'b111};

	// R10 R26 one step, then clamp
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (dn_step && ctrl_q != 6'h00)
			ctrl_d = ctrl_q - 6'h01;
		else if (up_step && ctrl_q != 6'h3f)
			ctrl_d = ctrl_q + 6'h01;
		ctrl_d = clamp(ctrl_d, lo, hi);
	end

	// R12 limiter ceiling caught on the enabling edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			on_q  <= 1'b0;
			cap_q <= 6'h00;
		end
		else
		begin
			on_q <= on;
			if (on && !on_q)
				cap_q <= amp_q;
		end
	end

	// R3 disabled controller shadows the amplifier
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= alc_pkg::RST_AMP;
		else if (!on)
			ctrl_q <= amp_wr ? pwdata[5:0] : amp_q;
		else
			ctrl_q <= ctrl_d;
	end

	// R24 crossing seen as sign change between samples
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sign_q <= 1'b0;
		else if (adc_valid)
			sign_q <= adc_sample[23];
	end

	assign zc_evt  = adc_valid && (adc_sample[23] != sign_q);
	assign pending = on && (ctrl_q != amp_q);
	// R24 R25 crossing or timeout releases a pending change
	assign apply   = pending && (!zc_en || zc_evt || (zc_cnt_q >= ZC_TIMEOUT - 32'h1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			zc_cnt_q <= 32'h0;
		else if (!pending || apply)
			zc_cnt_q <= 32'h0;
		else
			zc_cnt_q <= zc_cnt_q + 32'h1;
	end

	// R3 R11 software write reaches the amplifier only when disabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			amp_q <= alc_pkg::RST_AMP;
		else if (!on && amp_wr)
			amp_q <= pwdata[5:0];
		else if (apply)
			amp_q <= ctrl_q;
	end

	assign amp_gain = amp_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_disabled_hold: assert property (!on && !amp_wr |=> $stable(amp_q)) // R3
		else $error("amplifier gain moved while controller off");
	a_sw_ignored: assert property (on && amp_wr && !apply |=> $stable(amp_q)) // R11
		else $error("software gain reached amplifier while enabled");
	a_gain_range: assert property (on && lo <= hi // R10
		|=> ctrl_q >= $past(lo) && ctrl_q <= $past(hi))
		else $error("controller gain outside limits");
	a_limiter_cap: assert property (on && lim && on_q && cap_q >= lo // R12
		|-> ##1 ctrl_q <= $past(cap_q))
		else $error("limiter exceeded enable-time gain");
	a_step_down: assert property (dn_step && ctrl_q > lo && ctrl_q <= hi // R26
		|=> ctrl_q == $past(ctrl_q) - 6'h01)
		else $error("attack step not exactly one code");
	a_peak_load: assert property (adc_valid && abs_s > peak_q |=> peak_q == $past(abs_s)) // R17
		else $error("peak did not load larger sample");
	a_peak_decay: assert property (adc_valid && abs_s <= peak_q && peak_q != 24'h0 // R17
		|=> peak_q < $past(peak_q))
		else $error("peak failed to decay");
	a_hold_first: assert property (on && !lim && low && hold_cnt_q < hold_per // R14
		|=> hold_cnt_q == $past(hold_cnt_q) + 32'h1)
		else $error("hold count stalled before hold elapsed");
	a_gate_hold: assert property (gated |-> !up_step) // R21
		else $error("gain raised while gated");
	a_zc_timeout: assert property (pending && zc_cnt_q >= ZC_TIMEOUT - 32'h1 // R25
		|=> amp_q == $past(ctrl_q))
		else $error("pending gain not forced at timeout");
	a_no_zc_direct: assert property (pending && !zc_en |=> amp_q == $past(ctrl_q)) // R24
		else $error("gain change delayed without zero-cross gating");

	c_attack: cover property (dn_step ##1 amp_q != $past(amp_q));
	c_decay: cover property (up_step);
	c_clip: cover property (clip_q && atk_tick);
	c_zc_wait: cover property (pending && zc_en ##1 pending ##1 apply);
endmodule : input_auto_level_control

// ===== dv/adc_model.sv
// Decimator output model: alternating-sign samples of a set magnitude
`timescale 1ns/10ps
module adc_model #(
	parameter int unsigned RATE = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [23:0] level,
	output logic      [23:0] adc_sample,
	output logic             adc_valid
);
	logic [7:0] cnt_q;
	logic       neg_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q      <= 8'h00;
			neg_q      <= 1'b0;
			adc_valid  <= 1'b0;
			adc_sample <= 24'h000000;
		end
		else
		begin
			adc_valid <= (cnt_q == 8'(RATE - 1));
			cnt_q     <= (cnt_q == 8'(RATE - 1)) ? 8'h00 : cnt_q + 8'h01;
			if (cnt_q == 8'(RATE - 1))
			begin
				neg_q      <= ~neg_q;
				adc_sample <= neg_q ? -level : level;
			end
			else
				// Unqualified cycles must not look like a held sample
				adc_sample <= ~adc_sample;
		end
	end
endmodule : adc_model

// ===== dv/input_auto_level_control_tb.sv
// Self-checking bench for the input level controller
`timescale 1ns/10ps
`define chk(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module input_auto_level_control_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [9:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [23:0] adc_sample;
	logic        adc_valid;
	logic [5:0]  amp_gain;
	logic [23:0] level;
	int          error_cnt;
	int          cmp_count;

	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;

	// Short step bases; hold and crossing timeout keep full length
	input_auto_level_control #(
		.ATK_N_BASE(20), .ATK_L_BASE(5), .DCY_N_BASE(40), .DCY_L_BASE(20),
		.PEAK_SHIFT(4)
	) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_sample(adc_sample),
		.adc_valid(adc_valid), .amp_gain(amp_gain)
	);

	adc_model src (
		.pclk(pclk), .presetn(presetn), .level(level),
		.adc_sample(adc_sample), .adc_valid(adc_valid)
	);

	task automatic results();
		$display("Counts: %0d compared, %0d mismatched", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 16)
		begin
			error_cnt++;
			results();
		end
	endtask : apb

	task automatic wr(input logic [9:0] a, input logic [8:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, {23'h0, d}, q, e);
	endtask : wr

	task automatic steady(input int n, input logic [5:0] g);
		int i;
		#1;
		for (i = 0; i < n && amp_gain === g; i++)
		begin
			@(posedge pclk);
			#1;
		end
		`chk("held gain", g, amp_gain)
	endtask : steady

	// Waits for a gain, checking every change is a single step
	task automatic settle(input logic [5:0] g, input int lim, output int f, output int t);
		logic [5:0] p;
		p = amp_gain;
		f = -1;
		for (t = 0; t < lim && amp_gain !== g; t++)
		begin
			@(posedge pclk);
			#1;
			if (amp_gain !== p)
			begin
				if (f < 0)
					f = t;
				`chk("gain step", 6'h01, (amp_gain > p) ? amp_gain - p : p - amp_gain)
				p = amp_gain;
			end
		end
		`chk("settled gain", g, amp_gain)
		if (amp_gain !== g)
			results();
	endtask : settle

	task automatic t_regs();
		logic [9:0]  a [5];
		logic [31:0] m [5];
		logic [31:0] q;
		logic        e;
		a = '{alc_pkg::ADR_LIMITS, alc_pkg::ADR_TARGET, alc_pkg::ADR_TIMING,
			alc_pkg::ADR_GATE, alc_pkg::ADR_AMP};
		m = '{32'h1ff, 32'h1ff, 32'h1ff, 32'h00f, 32'h03f};
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, a[i], 32'h0, q, e);
			`chk("reset value", 32'h0, q)
			apb(1'b1, a[i], 32'hffffffff, q, e);
			apb(1'b0, a[i], 32'h0, q, e);
			`chk("readback", m[i], q)
			apb(1'b1, a[i], 32'h0, q, e);
		end
		apb(1'b0, 10'h3fc, 32'h0, q, e);
		`chk("unmapped error", 1'b1, e)
		`chk("unmapped data", 32'h0, q)
		$display("Test registers done");
	endtask : t_regs

	task automatic t_attack();
		int f;
		int t;
		wr(alc_pkg::ADR_AMP, 9'h028);
		level <= 24'h400000;
		wr(alc_pkg::ADR_LIMITS, 9'h13b);
		settle(6'h18, 2000, f, t);
		wr(alc_pkg::ADR_AMP, 9'h03f);
		steady(200, 6'h18);
		wr(alc_pkg::ADR_LIMITS, 9'h03b);
		steady(200, 6'h18);
		wr(alc_pkg::ADR_AMP, 9'h00a);
		steady(2, 6'h0a);
		$display("Test attack done");
	endtask : t_attack

	task automatic t_decay();
		int f;
		int t;
		level <= 24'h047000;
		// Peak must fall from the attack level before enabling
		steady(300, 6'h0a);
		wr(alc_pkg::ADR_TARGET, 9'h010);
		wr(alc_pkg::ADR_LIMITS, 9'h110);
		steady(400, 6'h0a);
		level <= 24'h020000;
		// Hold code 1 at full length cannot expire in this wait
		steady(400, 6'h0a);
		wr(alc_pkg::ADR_TARGET, 9'h000);
		settle(6'h17, 3000, f, t);
		`chk("hold release", 1'b1, f >= 0 && f < 100)
		steady(200, 6'h17);
		wr(alc_pkg::ADR_LIMITS, 9'h010);
		$display("Test decay done");
	endtask : t_decay

	task automatic t_gate();
		int f;
		int t;
		wr(alc_pkg::ADR_AMP, 9'h00a);
		wr(alc_pkg::ADR_GATE, 9'h00f);
		wr(alc_pkg::ADR_LIMITS, 9'h138);
		steady(400, 6'h0a);
		wr(alc_pkg::ADR_GATE, 9'h008);
		settle(6'h14, 1000, f, t);
		wr(alc_pkg::ADR_LIMITS, 9'h038);
		wr(alc_pkg::ADR_GATE, 9'h000);
		$display("Test gate done");
	endtask : t_gate

	task automatic t_limiter();
		int f;
		int t;
		wr(alc_pkg::ADR_TIMING, 9'h100);
		wr(alc_pkg::ADR_LIMITS, 9'h138);
		steady(400, 6'h14);
		level <= 24'h400000;
		settle(6'h00, 1000, f, t);
		`chk("fast attack", 1'b1, t < 200)
		level <= 24'h020000;
		settle(6'h14, 1000, f, t);
		`chk("fast decay", 1'b1, f >= 0 && (t - f) < 500)
		steady(200, 6'h14);
		wr(alc_pkg::ADR_LIMITS, 9'h038);
		$display("Test limiter done");
	endtask : t_limiter

	task automatic t_clip();
		int f;
		int t;
		wr(alc_pkg::ADR_AMP, 9'h030);
		wr(alc_pkg::ADR_TIMING, 9'h00a);
		wr(alc_pkg::ADR_TARGET, 9'h100);
		level <= 24'h780000;
		wr(alc_pkg::ADR_LIMITS, 9'h138);
		settle(6'h28, 400, f, t);
		wr(alc_pkg::ADR_LIMITS, 9'h038);
		$display("Test clip done");
	endtask : t_clip

	initial
	begin
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 10'h000;
		pwdata    = 32'h0;
		level     = 24'h000000;
		error_cnt = 0;
		cmp_count = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_attack();
		t_decay();
		t_gate();
		t_limiter();
		t_clip();
		results();
	end
endmodule : input_auto_level_control_tb
